/* File: hdl/dts_gap_timer.sv */
`timescale 1ns/1ns
module dts_gap_timer
  import dts_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] gapValue,
  output logic            busy
);

  typedef struct packed {
    logic [7:0] cnt;
  } dts_tmr_s;

  dts_tmr_s s_q;
  dts_tmr_s s_d;

  // ---------------------------------------------------------------
  // Countdown, loaded with field value: free after value+1 cycles
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.cnt = gapValue;
    end
    else if (s_q.cnt != 8'h00)
    begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.cnt != 8'h00);

endmodule : dts_gap_timer

/* File: hdl/dts_pkg.sv */
package dts_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_TIM1   = 8'h04;
  localparam logic [7:0] REG_TIM2   = 8'h08;
  localparam logic [7:0] REG_PRIO   = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_UNLOCK_BIT = 0;
  localparam int TIM1_WTR_LSB   = 0;
  localparam int TIM2_LEAD_LSB  = 23;
  localparam int TIM2_SXNR_LSB  = 16;
  localparam int TIM2_SXRD_LSB  = 8;
  localparam int TIM2_RTP_LSB   = 5;
  localparam int TIM2_CKE_LSB   = 0;
  localparam int PRIO_CNT_LSB   = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic       RST_UNLOCK = 1'b0;
  localparam logic [1:0] RST_WTR    = 2'h3;
  localparam logic [1:0] RST_LEAD   = 2'h3;
  localparam logic [6:0] RST_SXNR   = 7'h7F;
  localparam logic [7:0] RST_SXRD   = 8'hFF;
  localparam logic [2:0] RST_RTP    = 3'h7;
  localparam logic [4:0] RST_CKE    = 5'h1F;
  localparam logic [7:0] RST_PRIO   = 8'hFF;
  localparam logic [7:0] PRIO_OFF   = 8'hFF;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [1:0] BURST_BEATS = 2'h3; // Last beat index, 4 beats
  localparam int         NUM_TMR     = 5;
  localparam int         TMR_WTR     = 0;
  localparam int         TMR_SXNR    = 1;
  localparam int         TMR_SXRD    = 2;
  localparam int         TMR_RTP     = 3;
  localparam int         TMR_CKE     = 4;
  localparam logic [8:0] SINCE_MAX   = 9'h1FF;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_OTHER,
    CMD_SR_ENTER,
    CMD_SR_EXIT
  } dts_cmd_e;

  typedef enum logic [1:0] {
    WPH_IDLE,
    WPH_LEAD,
    WPH_DATA
  } dts_wph_e;

endpackage : dts_pkg

/* File: hdl/dts_timing_ctrl.sv */
`timescale 1ns/1ns
// Function
// - A read waits write-to-read value plus one cycles after the last write beat.
// - Second timing register takes writes only while timing unlock is set.
// - Reserved upper bits of second timing and priority registers read zero.
// - Termination enable rises lead-field cycles before write data is driven.
// - After self-refresh exit, non-read commands wait exit-nonread plus one.
// - After self-refresh exit, reads wait exit-read plus one cycles.
// - Precharge waits read-to-precharge plus one cycles after the last read.
// - Clock-enable transitions are at least clock-enable field plus one apart.
// - Oldest queued command gets a priority boost after enough transfers.
// - Boost count field N means N plus one transfers before the boost.
// - Boost count field of all ones disables the boost entirely.
module dts_timing_ctrl
  import dts_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      regAddr,
  input  wire logic [31:0]     regWrData,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic [31:0]          regRdData,
  input  wire logic            cmdValid,
  input  wire dts_pkg::dts_cmd_e cmdKind,
  output logic                 cmdReady,
  input  wire logic            xferDone,
  input  wire logic            queueNonEmpty,
  output logic                 boostOldest,
  output logic                 odtEn,
  output logic                 wrDataEn,
  output logic                 memCke
);

  typedef struct packed {
    logic        unlock;
    logic [1:0]  wtr;
    logic [1:0]  termLead;
    logic [6:0]  sxnr;
    logic [7:0]  sxrd;
    logic [2:0]  rtp;
    logic [4:0]  ckeGap;
    logic [7:0]  prio;
    logic [31:0] rdData;
    dts_wph_e    phase;
    logic [1:0]  leadCnt;
    logic [1:0]  beatCnt;
    logic        odt;
    logic        dataEn;
    logic        cke;
    logic [7:0]  xferCnt;
    logic        boost;
  } dts_state_s;

  dts_state_s s_q;
  dts_state_s s_d;

  logic [NUM_TMR-1:0] tmrLoad;
  logic [NUM_TMR-1:0] tmrBusy;
  logic [7:0]         tmrValue [NUM_TMR];
  logic               cmdIssue;
  logic               wrLastBeat;
  logic               inSelfRef;
  logic [31:0]        tim2Word;

  // ---------------------------------------------------------------
  // Spacing timers
  // ---------------------------------------------------------------
  assign tmrValue[TMR_WTR]  = {6'h00, s_q.wtr};
  assign tmrValue[TMR_SXNR] = {1'b0, s_q.sxnr};
  assign tmrValue[TMR_SXRD] = s_q.sxrd;
  assign tmrValue[TMR_RTP]  = {5'h00, s_q.rtp};
  assign tmrValue[TMR_CKE]  = {3'h0, s_q.ckeGap};

  generate
    for (genvar i = 0; i < NUM_TMR; i++)
    begin : gTmr
      dts_gap_timer uTmr (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (tmrLoad[i]),
        .gapValue (tmrValue[i]),
        .busy     (tmrBusy[i])
      );
    end
  endgenerate

  assign wrLastBeat = (s_q.phase == WPH_DATA) &&
                      (s_q.beatCnt == BURST_BEATS);
  assign inSelfRef  = !s_q.cke;
  assign cmdIssue   = cmdValid && cmdReady;
  assign tim2Word   = {7'h00, s_q.termLead, s_q.sxnr, s_q.sxrd,
                       s_q.rtp, s_q.ckeGap};

  // ---------------------------------------------------------------
  // Command gate
  // ---------------------------------------------------------------
  always_comb
  begin
    cmdReady = 1'b0;
    case (cmdKind)
      CMD_READ:
        cmdReady = !inSelfRef && !tmrBusy[TMR_WTR] &&
                   !tmrBusy[TMR_SXRD] &&
                   (s_q.phase == WPH_IDLE);
      CMD_WRITE:
        cmdReady = !inSelfRef && !tmrBusy[TMR_SXNR] &&
                   (s_q.phase == WPH_IDLE);
      CMD_PRECHARGE:
        cmdReady = !inSelfRef && !tmrBusy[TMR_SXNR] &&
                   !tmrBusy[TMR_RTP] &&
                   (s_q.phase == WPH_IDLE);
      CMD_OTHER:
        cmdReady = !inSelfRef && !tmrBusy[TMR_SXNR];
      CMD_SR_ENTER:
        cmdReady = !inSelfRef && !tmrBusy[TMR_SXNR] &&
                   !tmrBusy[TMR_CKE] &&
                   (s_q.phase == WPH_IDLE);
      CMD_SR_EXIT:
        cmdReady = inSelfRef && !tmrBusy[TMR_CKE];
      default:
        cmdReady = 1'b0;
    endcase
  end

  // Outside the gate process so that it never reads its own result
  assign tmrLoad[TMR_WTR]  = wrLastBeat;
  assign tmrLoad[TMR_RTP]  = cmdIssue && (cmdKind == CMD_READ);
  assign tmrLoad[TMR_CKE]  = cmdIssue && ((cmdKind == CMD_SR_ENTER) ||
                                          (cmdKind == CMD_SR_EXIT));
  assign tmrLoad[TMR_SXNR] = cmdIssue && (cmdKind == CMD_SR_EXIT);
  assign tmrLoad[TMR_SXRD] = cmdIssue && (cmdKind == CMD_SR_EXIT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d        = s_q;
    s_d.rdData = 32'h0000_0000;
    s_d.boost  = 1'b0;

    // Register writes
    if (regWr)
    begin
      case (regAddr)
        REG_CFG:
          s_d.unlock = regWrData[CFG_UNLOCK_BIT];
        REG_TIM1:
          s_d.wtr = regWrData[TIM1_WTR_LSB +: 2];
        REG_TIM2:
          if (s_q.unlock)
          begin
            s_d.termLead = regWrData[TIM2_LEAD_LSB +: 2];
            s_d.sxnr     = regWrData[TIM2_SXNR_LSB +: 7];
            s_d.sxrd     = regWrData[TIM2_SXRD_LSB +: 8];
            s_d.rtp      = regWrData[TIM2_RTP_LSB +: 3];
            s_d.ckeGap   = regWrData[TIM2_CKE_LSB +: 5];
          end
        REG_PRIO:
          s_d.prio = regWrData[PRIO_CNT_LSB +: 8];
        default:
          s_d.prio = s_q.prio;
      endcase
    end

    // Register reads, zero for unmapped and reserved bits
    if (regRd)
    begin
      case (regAddr)
        REG_CFG:
          s_d.rdData = {31'h0000_0000, s_q.unlock};
        REG_TIM1:
          s_d.rdData = {30'h0000_0000, s_q.wtr};
        REG_TIM2:
          s_d.rdData = tim2Word;
        REG_PRIO:
          s_d.rdData = {24'h00_0000, s_q.prio};
        REG_STATUS:
          s_d.rdData = {20'h0_0000, s_q.xferCnt, s_q.cke,
                        s_q.odt, s_q.phase};
        default:
          s_d.rdData = 32'h0000_0000;
      endcase
    end

    // Write burst: termination first, data after the lead
    case (s_q.phase)
      WPH_IDLE:
        if (cmdIssue && (cmdKind == CMD_WRITE))
        begin
          s_d.odt     = 1'b1;
          s_d.beatCnt = 2'h0;
          if (s_q.termLead == 2'h0)
          begin
            s_d.dataEn = 1'b1;
            s_d.phase  = WPH_DATA;
          end
          else
          begin
            s_d.leadCnt = s_q.termLead - 2'h1;
            s_d.phase   = WPH_LEAD;
          end
        end
      WPH_LEAD:
        if (s_q.leadCnt == 2'h0)
        begin
          s_d.dataEn = 1'b1;
          s_d.phase  = WPH_DATA;
        end
        else
        begin
          s_d.leadCnt = s_q.leadCnt - 2'h1;
        end
      WPH_DATA:
        if (wrLastBeat)
        begin
          s_d.dataEn = 1'b0;
          s_d.odt    = 1'b0;
          s_d.phase  = WPH_IDLE;
        end
        else
        begin
          s_d.beatCnt = s_q.beatCnt + 2'h1;
        end
      default:
        s_d.phase = WPH_IDLE;
    endcase

    // Clock enable follows self-refresh entry and exit
    if (cmdIssue && (cmdKind == CMD_SR_ENTER))
    begin
      s_d.cke = 1'b0;
    end
    else if (cmdIssue && (cmdKind == CMD_SR_EXIT))
    begin
      s_d.cke = 1'b1;
    end

    // Starvation guard; an empty queue has no oldest entry
    if (!queueNonEmpty || (s_q.prio == PRIO_OFF))
    begin
      s_d.xferCnt = 8'h00;
    end
    else if (xferDone)
    begin
      if (s_q.xferCnt == s_q.prio)
      begin
        s_d.boost   = 1'b1;
        s_d.xferCnt = 8'h00;
      end
      else
      begin
        s_d.xferCnt = s_q.xferCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.unlock   <= RST_UNLOCK;
      s_q.wtr      <= RST_WTR;
      s_q.termLead <= RST_LEAD;
      s_q.sxnr     <= RST_SXNR;
      s_q.sxrd     <= RST_SXRD;
      s_q.rtp      <= RST_RTP;
      s_q.ckeGap   <= RST_CKE;
      s_q.prio     <= RST_PRIO;
      s_q.phase    <= WPH_IDLE;
      s_q.cke      <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRdData   = s_q.rdData;
  assign boostOldest = s_q.boost;
  assign odtEn       = s_q.odt;
  assign wrDataEn    = s_q.dataEn;
  assign memCke      = s_q.cke;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [8:0] sinceWr;
  logic [8:0] sinceExit;
  logic [8:0] sinceRd;
  logic [8:0] sinceCke;
  logic [2:0] odtAge;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sinceWr   <= SINCE_MAX;
      sinceExit <= SINCE_MAX;
      sinceRd   <= SINCE_MAX;
      sinceCke  <= SINCE_MAX;
      odtAge    <= 3'h0;
    end
    else
    begin
      sinceWr   <= wrLastBeat ? 9'h000 :
                   (sinceWr == SINCE_MAX ? sinceWr : sinceWr + 9'h001);
      sinceExit <= (cmdIssue && cmdKind == CMD_SR_EXIT) ? 9'h000 :
                   (sinceExit == SINCE_MAX ? sinceExit
                                           : sinceExit + 9'h001);
      sinceRd   <= (cmdIssue && cmdKind == CMD_READ) ? 9'h000 :
                   (sinceRd == SINCE_MAX ? sinceRd : sinceRd + 9'h001);
      sinceCke  <= tmrLoad[TMR_CKE] ? 9'h000 :
                   (sinceCke == SINCE_MAX ? sinceCke : sinceCke + 9'h001);
      odtAge    <= !odtEn ? 3'h0 :
                   (odtAge == 3'h7 ? odtAge : odtAge + 3'h1);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  read_after_wr_a: assert property (
    cmdIssue && cmdKind == CMD_READ |-> sinceWr >= {7'h00, s_q.wtr})
    else $error("read too soon after write data");

  tim2_locked_a: assert property (
    regWr && regAddr == REG_TIM2 && !s_q.unlock |=> $stable(tim2Word))
    else $error("locked timing write took effect");

  tim2_resv_a: assert property (
    regRd && regAddr == REG_TIM2 |=> regRdData[31:25] == 7'h00)
    else $error("timing reserved bits not zero");

  prio_resv_a: assert property (
    regRd && regAddr == REG_PRIO |=> regRdData[31:8] == 24'h00_0000)
    else $error("priority reserved bits not zero");

  odt_lead_a: assert property (
    $rose(wrDataEn) |-> odtEn && odtAge == {1'b0, s_q.termLead})
    else $error("termination lead wrong");

  exit_nonrd_a: assert property (
    cmdIssue && cmdKind != CMD_READ && cmdKind != CMD_SR_EXIT
      |-> sinceExit >= {2'h0, s_q.sxnr})
    else $error("non-read too soon after self-refresh exit");

  exit_rd_a: assert property (
    cmdIssue && cmdKind == CMD_READ |-> sinceExit >= {1'b0, s_q.sxrd})
    else $error("read too soon after self-refresh exit");

  rd_to_pre_a: assert property (
    cmdIssue && cmdKind == CMD_PRECHARGE |-> sinceRd >= {6'h00, s_q.rtp})
    else $error("precharge too soon after read");

  cke_gap_a: assert property (
    tmrLoad[TMR_CKE] |-> sinceCke >= {4'h0, s_q.ckeGap}
                         ##1 $changed(memCke))
    else $error("clock enable toggled too soon");

  boost_fire_a: assert property (
    xferDone && queueNonEmpty && s_q.prio != PRIO_OFF &&
    s_q.xferCnt == s_q.prio |=> boostOldest ##1 (!boostOldest ||
      $past(xferDone && queueNonEmpty && s_q.prio == 8'h00)))
    else $error("boost missed at threshold");

  boost_off_a: assert property (
    s_q.prio == PRIO_OFF |=> !boostOldest)
    else $error("boost while disabled");

  wr_burst_c: cover property ($rose(wrDataEn) ##4 $fell(wrDataEn));
  exit_read_c: cover property (
    cmdIssue && cmdKind == CMD_SR_EXIT ##[1:300]
    cmdIssue && cmdKind == CMD_READ);
  boost_c: cover property (boostOldest);
  locked_wr_c: cover property (regWr && regAddr == REG_TIM2 && !s_q.unlock);

endmodule : dts_timing_ctrl

/* File: test/dts_sdram_model.sv */
`timescale 1ns/1ns
module dts_sdram_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       odtEn,
  input  wire logic       wrDataEn,
  input  wire logic       memCke,
  output logic            burstDone,
  output logic [3:0]      leadSeen,
  output logic [3:0]      beatsSeen,
  output logic [7:0]      ckeGapSeen
);
  logic [3:0] leadCnt;
  logic [3:0] beatCnt;
  logic [7:0] ckeCnt;
  logic       ckeLast;

  // ----------------------------------------
  // Memory-side observation
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    burstDone <= 1'b0;
    if (rst)
    begin
      leadCnt    <= 4'h0;
      beatCnt    <= 4'h0;
      ckeCnt     <= 8'h01;
      ckeLast    <= 1'b1;
      leadSeen   <= 4'h0;
      beatsSeen  <= 4'h0;
      ckeGapSeen <= 8'h00;
    end
    else
    begin
      // Termination has to be on before the first data beat
      if (!odtEn)
        leadCnt <= 4'h0;
      else if (!wrDataEn && beatCnt == 4'h0)
        leadCnt <= leadCnt + 4'h1;
      if (wrDataEn)
        beatCnt <= beatCnt + 4'h1;
      else if (beatCnt != 4'h0)
      begin
        beatsSeen <= beatCnt;
        leadSeen  <= leadCnt;
        beatCnt   <= 4'h0;
        burstDone <= 1'b1;
      end
      ckeLast <= memCke;
      if (memCke != ckeLast)
      begin
        ckeGapSeen <= ckeCnt;
        ckeCnt     <= 8'h01;
      end
      else if (ckeCnt != 8'hFF)
        ckeCnt <= ckeCnt + 8'h01;
    end
  end
endmodule : dts_sdram_model

/* File: test/dts_timing_ctrl_tb.sv */
`timescale 1ns/1ns
module dts_timing_ctrl_tb;
  import dts_pkg::*;
  logic        ref_clk       = 1'b0;
  logic        rst           = 1'b1;
  logic [7:0]  regAddr       = 8'h00;
  logic [31:0] regWrData     = 32'h0000_0000;
  logic        regWr         = 1'b0;
  logic        regRd         = 1'b0;
  logic        cmdValid      = 1'b0;
  dts_cmd_e    cmdKind       = CMD_OTHER;
  logic        xferPulse     = 1'b0;
  logic        queueNonEmpty = 1'b0;
  logic [31:0] regRdData;
  logic        cmdReady;
  logic        boostOldest;
  logic        odtEn;
  logic        wrDataEn;
  logic        memCke;
  logic        burstDone;
  logic [3:0]  leadSeen;
  logic [3:0]  beatsSeen;
  logic [7:0]  ckeGapSeen;
  int          nErrors        = 0;
  int          samplesChecked = 0;
  int          cycles         = 0;
  int          boostCnt       = 0;

  always #4 ref_clk = ~ref_clk;

  dts_timing_ctrl i_dts_timing_ctrl (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdReady(cmdReady), .xferDone(xferPulse | burstDone),
    .queueNonEmpty(queueNonEmpty), .boostOldest(boostOldest),
    .odtEn(odtEn), .wrDataEn(wrDataEn), .memCke(memCke));

  dts_sdram_model i_dts_sdram_model (
    .ref_clk(ref_clk), .rst(rst), .odtEn(odtEn), .wrDataEn(wrDataEn),
    .memCke(memCke), .burstDone(burstDone), .leadSeen(leadSeen),
    .beatsSeen(beatsSeen), .ckeGapSeen(ckeGapSeen));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task finish_test;
    if (nErrors == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_wr

  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, exp);
    @(posedge ref_clk);
  endtask : reg_rd

  // Offers a command and checks how many cycles it was held off;
  // valid stays high so the next offer follows with no gap
  task issue(input dts_cmd_e k, input int exp);
    int n;
    n = 0;
    cmdValid <= 1'b1;
    cmdKind  <= k;
    #1;
    while (cmdReady !== 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n, exp);
    @(posedge ref_clk);
  endtask : issue

  task cmd_idle;
    cmdValid <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask : cmd_idle

  task boost_run(input logic [7:0] prio, input int pulses, input int exp);
    int base;
    reg_wr(REG_PRIO, {24'h00_0000, prio});
    queueNonEmpty <= 1'b1;
    base = boostCnt;
    xferPulse <= 1'b1;
    repeat (pulses) @(posedge ref_clk);
    xferPulse <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(boostCnt - base, exp);
    queueNonEmpty <= 1'b0;
    @(posedge ref_clk);
  endtask : boost_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_registers;
    reg_rd(REG_TIM2, 32'h01FF_FFFF);
    reg_rd(REG_PRIO, 32'h0000_00FF);
    reg_rd(8'h14, 32'h0000_0000);
    reg_rd(REG_STATUS, {28'h000_0000, 1'b1, 1'b0, WPH_IDLE});
    reg_wr(REG_TIM2, 32'h0000_0000);
    reg_rd(REG_TIM2, 32'h01FF_FFFF);
    reg_wr(REG_CFG, 32'h0000_0001);
    reg_rd(REG_CFG, 32'h0000_0001);
    // Lead 1 keeps below a CAS latency of 4 minus one
    reg_wr(REG_TIM2, 32'hFE82_0443);
    reg_rd(REG_TIM2, 32'h0082_0443);
    reg_wr(REG_TIM1, 32'h0000_0001);
    reg_rd(REG_TIM1, 32'h0000_0001);
    reg_wr(REG_PRIO, 32'hFFFF_FF01);
    reg_rd(REG_PRIO, 32'h0000_0001);
  endtask : test_registers

  task test_write_read;
    issue(CMD_WRITE, 0);
    // Lead 1, four beats, then write-to-read 1 plus one
    issue(CMD_READ, 6);
    issue(CMD_PRECHARGE, 2);
    cmd_idle();
    chk(leadSeen, 1);
    chk(beatsSeen, 4);
  endtask : test_write_read

  task test_selfref;
    issue(CMD_SR_ENTER, 0);
    issue(CMD_SR_EXIT, 3);
    issue(CMD_OTHER, 2);
    issue(CMD_READ, 1);
    cmd_idle();
    chk(ckeGapSeen, 4);
    chk(memCke, 1'b1);
  endtask : test_selfref

  task test_boost;
    boost_run(8'h01, 1, 0);
    boost_run(8'h01, 2, 1);
    boost_run(8'h00, 1, 1);
    boost_run(8'h02, 3, 1);
    boost_run(8'hFF, 260, 0);
  endtask : test_boost

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (boostOldest === 1'b1)
      boostCnt++;
    if (cycles == 20000)
    begin
      nErrors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    test_registers();
    test_write_read();
    test_selfref();
    test_boost();
    finish_test();
  end
endmodule : dts_timing_ctrl_tb
